/* File: rtl/sltc_regs.vh */
// Purpose: constants of the serial link transmit control block
// Assumes: 8-bit register port, one octet per lane clock
// Notes: definitions only
`ifndef SLTC_REGS_VH
`define SLTC_REGS_VH
// ****************************************
// register offsets
// ****************************************
`define SLTC_OFS_ALIGN 8'h01
`define SLTC_OFS_SYNC 8'h02
`define SLTC_OFS_PATT 8'h03
`define SLTC_OFS_KCNT 8'h07
// ****************************************
// reset values
// ****************************************
`define SLTC_RST_ALIGN 8'h00
`define SLTC_RST_SYNC 8'h00
`define SLTC_RST_PATT 8'h04
`define SLTC_RST_KCNT 5'h00
// ****************************************
// field positions
// ****************************************
`define SLTC_B_KOVR 7
`define SLTC_B_TPEN 4
`define SLTC_B_LANE 2
`define SLTC_B_FRAME 1
`define SLTC_B_SUPP 0
`define SLTC_B_SWSYNC 7
`define SLTC_B_SWSEL 6
`define SLTC_B_FLIP 4
`define SLTC_B_MASK 3
`define SLTC_B_ASMID 2
`define SLTC_B_ASMHI 1
`define SLTC_B_RAMP 0
`define SLTC_MASK_ALIGN 8'h97
`define SLTC_MASK_SYNC 8'hcf
// ****************************************
// codes and counts
// ****************************************
`define SLTC_PK_14 2'b00
`define SLTC_PK_12 2'b11
`define SLTC_LP_DATA 3'b000
`define SLTC_LP_D215 3'b001
`define SLTC_LP_K285 3'b010
`define SLTC_LP_ILAS 3'b011
`define SLTC_LP_RPAT 3'b100
`define SLTC_K_R 8'h1c
`define SLTC_K_A 8'h7c
`define SLTC_K_Q 8'h9c
`define SLTC_K_K 8'hbc
`define SLTC_K_F 8'hfc
`define SLTC_D_215 8'hb5
`define SLTC_K_DEFAULT 5'd4
`define SLTC_ILAS_MF 2'd3
`define SLTC_RPAT_LAST 4'd11
`endif

/* File: rtl/sltc_top.v */
// Purpose: transmit link layer control of a dual-channel converter lane
// Assumes: synchronous inputs, one octet per clock, two octets per frame
// Notes: fifo module and top module share this file
//
// Contract
// (RULE1) override bit 7 clear gives five frames per multiframe, set uses programmed count
// (RULE2) transport test bit 4 replaces samples with the long transport pattern
// (RULE3) lane align bit 2 inserts K28.3 at multiframe ends
// (RULE4) frame align bit 1 inserts K28.7 at frame ends
// (RULE5) suppress bit 0 skips the alignment sequence after sync release
// (RULE6) sync select bit 6 ignores the sync pins, uses the software bit
// (RULE7) software sync bit 7 under software control sends K28.5 only
// (RULE8) packing 00 gives 14-bit output, 11 gives packed 12-bit output
// (RULE9) frame assembly select bits choose the assembly, one resets to one
// (RULE10) link pattern 000 data, 001 D21.5, 010 K28.5, 100 RPAT
// (RULE11) link pattern 011 sends K28.5 then repeats alignment sequence forever
// (RULE12) disparity flip bit 4 acts only while link pattern is 100
// (RULE13) ramp bit 0 outputs a ramp only in packed 12-bit configuration
// (RULE14) programmed frames per multiframe is stored value plus one
// (RULE15) sync active sends K28.5; release starts alignment at multiframe boundary
`timescale 1ns/1ps
`include "sltc_regs.vh"

module sltc_fifo #(
  parameter W = 14,
  parameter D = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire srst,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [W-1:0] mem_q [0:D-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  reg room_q;
  wire push;
  wire pop;
  assign in_ready = room_q;
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
    if (srst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      room_q <= 1'b1;
    end else begin
      room_q <= ~(((cnt_q == D[AW:0] - 1'b1) & push & ~pop) | (~room_q & ~pop));
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

module sltc_top (
  input wire clk,
  input wire srst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_we,
  input wire reg_re,
  output reg [7:0] reg_rdata_q,
  input wire sync_request_pins_n,
  input wire [13:0] sample_data,
  input wire sample_valid,
  output wire sample_ready,
  output reg [7:0] lane_octet_q,
  output reg lane_is_k_q,
  output reg lane_valid_q,
  output reg lane_disparity_flip_q,
  output reg [1:0] packed_output_select_q,
  output reg [1:0] frame_assembly_select_low_q,
  output reg frame_assembly_select_mid_q,
  output reg frame_assembly_select_high_q,
  output reg multiframe_clock_mask_clear_q,
  output reg [2:0] link_state_q
);
  // ****************************************
  // states and register storage
  // ****************************************
  localparam ST_CGS = 3'b001;
  localparam ST_ILAS = 3'b010;
  localparam ST_DATA = 3'b100;
  reg [7:0] align_q;
  reg [7:0] sync_q;
  reg [7:0] patt_q;
  reg [4:0] kcnt_q;
  reg [2:0] state_d;
  reg octet_q;
  reg [4:0] frame_q;
  reg [1:0] mf_q;
  reg [3:0] rpat_q;
  reg [11:0] ramp_q;
  reg [7:0] low_q;
  reg [7:0] oct_d;
  reg k_d;
  reg [15:0] word_w;
  reg [7:0] rdata_d;

  wire [13:0] fifo_data;
  wire fifo_valid;
  wire [2:0] lpat;
  wire [4:0] k_last;
  wire mf_end;
  wire sync_act;
  wire samp_mode;
  wire ramp_on;
  wire need_pop;
  wire stall;

  // ****************************************
  // rpat octet table
  // ****************************************
  function [7:0] rpat_octet;
    input [3:0] idx;
    begin
      case (idx)
        4'd0: rpat_octet = 8'hbe;
        4'd1: rpat_octet = 8'hd7;
        4'd2: rpat_octet = 8'ha1;
        4'd3: rpat_octet = 8'he6;
        4'd4: rpat_octet = 8'h78;
        4'd5: rpat_octet = 8'h18;
        4'd6: rpat_octet = 8'h55;
        4'd7: rpat_octet = 8'ha2;
        4'd8: rpat_octet = 8'hb5;
        4'd9: rpat_octet = 8'h33;
        4'd10: rpat_octet = 8'h4a;
        default: rpat_octet = 8'hc3;
      endcase
    end
  endfunction

  // ****************************************
  // sample buffer
  // ****************************************
  sltc_fifo #(
    .W(14),
    .D(4),
    .AW(2)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_data(sample_data),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(need_pop)
  );

  // ****************************************
  // link decisions
  // ****************************************
  assign lpat = patt_q[7:5];
  assign k_last = align_q[`SLTC_B_KOVR] ? kcnt_q : `SLTC_K_DEFAULT; // RULE1 RULE14
  assign mf_end = octet_q & (frame_q >= k_last);
  assign sync_act = sync_q[`SLTC_B_SWSEL] ? sync_q[`SLTC_B_SWSYNC] // RULE6 RULE7
                                          : ~sync_request_pins_n;
  assign ramp_on = patt_q[`SLTC_B_RAMP] & (sync_q[3:2] == `SLTC_PK_12); // RULE13
  assign samp_mode = (link_state_q == ST_DATA) & (lpat == `SLTC_LP_DATA)
                     & ~align_q[`SLTC_B_TPEN] & ~ramp_on;
  assign need_pop = samp_mode & ~octet_q & ~sync_act;
  assign stall = need_pop & ~fifo_valid;

  // ****************************************
  // next state
  // ****************************************
  always @* begin
    state_d = link_state_q;
    if (sync_act) begin
      state_d = ST_CGS; // RULE15
    end else begin
      case (link_state_q)
        ST_CGS: begin
          if (mf_end) begin
            if (align_q[`SLTC_B_SUPP] & (lpat != `SLTC_LP_ILAS)) begin
              state_d = ST_DATA; // RULE5
            end else begin
              state_d = ST_ILAS; // RULE15
            end
          end
        end
        ST_ILAS: begin
          if (mf_end & (mf_q == `SLTC_ILAS_MF) & (lpat != `SLTC_LP_ILAS)) begin
            state_d = ST_DATA; // RULE11
          end
        end
        ST_DATA: begin
          if (lpat == `SLTC_LP_ILAS) begin
            state_d = ST_CGS; // RULE11
          end
        end
        default: state_d = ST_CGS;
      endcase
    end
  end

  // ****************************************
  // octet selection
  // ****************************************
  always @* begin
    word_w = 16'h0000;
    oct_d = 8'h00;
    k_d = 1'b0;
    if (align_q[`SLTC_B_TPEN]) begin
      word_w = {frame_q, 11'h000}; // RULE2
    end else if (ramp_on) begin
      word_w = {ramp_q, 4'h0}; // RULE13
    end else if (sync_q[3:2] == `SLTC_PK_12) begin
      word_w = {fifo_data[13:2], 4'h0}; // RULE8
    end else begin
      word_w = {fifo_data, 2'b00}; // RULE8
    end
    case (link_state_q)
      ST_CGS: begin
        oct_d = `SLTC_K_K; // RULE7 RULE15
        k_d = 1'b1;
      end
      ST_ILAS: begin
        if (~octet_q & (frame_q == 5'd0)) begin
          oct_d = `SLTC_K_R;
          k_d = 1'b1;
        end else if (mf_end) begin
          oct_d = `SLTC_K_A;
          k_d = 1'b1;
        end else if (octet_q & (frame_q == 5'd0) & (mf_q == 2'd1)) begin
          oct_d = `SLTC_K_Q;
          k_d = 1'b1;
        end else begin
          oct_d = {3'b000, frame_q};
        end
      end
      default: begin
        if (lpat == `SLTC_LP_D215) begin
          oct_d = `SLTC_D_215; // RULE10
        end else if (lpat == `SLTC_LP_K285) begin
          oct_d = `SLTC_K_K; // RULE10
          k_d = 1'b1;
        end else if (lpat == `SLTC_LP_RPAT) begin
          oct_d = rpat_octet(rpat_q); // RULE10
        end else if (octet_q & mf_end & align_q[`SLTC_B_LANE]) begin
          oct_d = `SLTC_K_A; // RULE3
          k_d = 1'b1;
        end else if (octet_q & align_q[`SLTC_B_FRAME]) begin
          oct_d = `SLTC_K_F; // RULE4
          k_d = 1'b1;
        end else if (octet_q) begin
          oct_d = low_q;
        end else begin
          oct_d = word_w[15:8];
        end
      end
    endcase
  end

  // ****************************************
  // register read decode
  // ****************************************
  always @* begin
    if (reg_addr == `SLTC_OFS_ALIGN) begin
      rdata_d = align_q;
    end else if (reg_addr == `SLTC_OFS_SYNC) begin
      rdata_d = sync_q;
    end else if (reg_addr == `SLTC_OFS_PATT) begin
      rdata_d = patt_q;
    end else if (reg_addr == `SLTC_OFS_KCNT) begin
      rdata_d = {3'b000, kcnt_q};
    end else begin
      rdata_d = 8'h00;
    end
  end

  // ****************************************
  // registers and link counters
  // ****************************************
  always @(posedge clk) begin
    if (srst) begin
      align_q <= `SLTC_RST_ALIGN;
      sync_q <= `SLTC_RST_SYNC;
      patt_q <= `SLTC_RST_PATT; // RULE9
      kcnt_q <= `SLTC_RST_KCNT;
      reg_rdata_q <= 8'h00;
      link_state_q <= ST_CGS;
      octet_q <= 1'b0;
      frame_q <= 5'd0;
      mf_q <= 2'd0;
      rpat_q <= 4'd0;
      ramp_q <= 12'h000;
      low_q <= 8'h00;
      lane_octet_q <= 8'h00;
      lane_is_k_q <= 1'b0;
      lane_valid_q <= 1'b0;
      lane_disparity_flip_q <= 1'b0;
      packed_output_select_q <= `SLTC_PK_14;
      frame_assembly_select_low_q <= 2'b00;
      frame_assembly_select_mid_q <= 1'b1;
      frame_assembly_select_high_q <= 1'b0;
      multiframe_clock_mask_clear_q <= 1'b0;
    end else begin
      if (reg_we) begin
        if (reg_addr == `SLTC_OFS_ALIGN) begin
          align_q <= reg_wdata & `SLTC_MASK_ALIGN;
        end else if (reg_addr == `SLTC_OFS_SYNC) begin
          sync_q <= reg_wdata & `SLTC_MASK_SYNC;
        end else if (reg_addr == `SLTC_OFS_PATT) begin
          patt_q <= reg_wdata;
        end else if (reg_addr == `SLTC_OFS_KCNT) begin
          kcnt_q <= reg_wdata[4:0];
        end
      end
      if (reg_re) begin
        reg_rdata_q <= rdata_d;
      end
      packed_output_select_q <= sync_q[3:2]; // RULE8
      frame_assembly_select_low_q <= sync_q[1:0]; // RULE9
      frame_assembly_select_mid_q <= patt_q[`SLTC_B_ASMID]; // RULE9
      frame_assembly_select_high_q <= patt_q[`SLTC_B_ASMHI]; // RULE9
      multiframe_clock_mask_clear_q <= patt_q[`SLTC_B_MASK];
      lane_disparity_flip_q <= patt_q[`SLTC_B_FLIP] & (lpat == `SLTC_LP_RPAT); // RULE12
      lane_valid_q <= ~stall;
      if (~stall) begin
        link_state_q <= state_d;
        lane_octet_q <= oct_d;
        lane_is_k_q <= k_d;
        octet_q <= ~octet_q;
        if (~octet_q) begin
          low_q <= word_w[7:0];
        end
        if (mf_end) begin
          frame_q <= 5'd0;
          mf_q <= (link_state_q == ST_ILAS) ? mf_q + 2'd1 : 2'd0;
        end else if (octet_q) begin
          frame_q <= frame_q + 5'd1;
        end
        if (rpat_q == `SLTC_RPAT_LAST) begin
          rpat_q <= 4'd0;
        end else begin
          rpat_q <= rpat_q + 4'd1;
        end
        if (ramp_on & octet_q) begin
          ramp_q <= ramp_q + 12'h001;
        end
      end
    end
  end
endmodule

/* File: bench/sltc_chk.sv */
// Purpose: port checks of the link transmit control block
// Assumes: one clock, srst synchronous active high
// Notes: sync and pattern register writes mirrored in helper flops
`timescale 1ns/1ps
`include "sltc_regs.vh"
module sltc_chk (
  input wire clk,
  input wire srst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_we,
  input wire sync_request_pins_n,
  input wire [7:0] lane_octet_q,
  input wire lane_is_k_q,
  input wire lane_disparity_flip_q,
  input wire [1:0] packed_output_select_q,
  input wire [1:0] frame_assembly_select_low_q,
  input wire [2:0] link_state_q
);
  // ****************************************
  // register mirror
  // ****************************************
  reg [7:0] sync_q;
  reg [7:0] patt_q;
  wire wr2 = reg_we && reg_addr == `SLTC_OFS_SYNC;
  always @(posedge clk) begin
    if (srst) begin
      sync_q <= `SLTC_RST_SYNC;
      patt_q <= `SLTC_RST_PATT;
    end else if (reg_we && reg_addr == `SLTC_OFS_PATT) begin
      patt_q <= reg_wdata;
    end else if (wr2) begin
      sync_q <= reg_wdata;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence pins_req;
    !sync_request_pins_n && !sync_q[6] && patt_q[7:5] != `SLTC_LP_ILAS;
  endsequence
  sequence sw_req;
    sync_q[7] && sync_q[6];
  endsequence
  sequence wr_once;
    wr2 ##1 !wr2;
  endsequence
  state_onehot_a: assert property ($onehot(link_state_q))
    else $error("link state not one-hot");
  sync_kchar_a: assert property ($past(link_state_q) == 3'b001 && link_state_q == 3'b001
    && !$past(srst) && !$past(srst, 2) |-> lane_octet_q == `SLTC_K_K && lane_is_k_q)
    else $error("no K28.5 while in sync");
  pins_sync_a: assert property (pins_req [*3] |-> link_state_q == 3'b001)
    else $error("pin request not honoured");
  sw_sync_a: assert property (sw_req [*3] |-> link_state_q == 3'b001)
    else $error("software request not honoured");
  flip_on_a: assert property (patt_q[7:4] == 4'h9 [*3] |-> lane_disparity_flip_q)
    else $error("flip missing");
  flip_off_a: assert property (patt_q[7:5] != `SLTC_LP_RPAT [*3] |-> !lane_disparity_flip_q)
    else $error("flip outside rpat");
  pack_copy_a: assert property (wr_once |-> ##1
    {packed_output_select_q, frame_assembly_select_low_q} == $past(reg_wdata[3:0], 2))
    else $error("packing copy wrong");
  ilas_entry_a: assert property ($rose(link_state_q[1]) |-> $past(link_state_q) == 3'b001)
    else $error("alignment not after sync");
endmodule
bind sltc_top sltc_chk u_chk (.clk(clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_we(reg_we), .sync_request_pins_n(sync_request_pins_n),
  .lane_octet_q(lane_octet_q), .lane_is_k_q(lane_is_k_q),
  .lane_disparity_flip_q(lane_disparity_flip_q), .packed_output_select_q(packed_output_select_q),
  .frame_assembly_select_low_q(frame_assembly_select_low_q), .link_state_q(link_state_q));

/* File: bench/sltc_rx_model.sv */
// Purpose: link receiver holding and releasing the sync request
// Assumes: releases after three K28.5 octets once allowed
// Notes: pin driven at all times
`timescale 1ns/1ps
`include "sltc_regs.vh"
module sltc_rx_model (
  input wire clk,
  input wire srst,
  input wire allow,
  input wire [7:0] lane_octet_q,
  input wire lane_is_k_q,
  output reg sync_request_pins_n
);
  reg [1:0] kcnt_q;
  always @(posedge clk) begin
    if (srst || !allow) begin
      kcnt_q <= 2'd0;
      sync_request_pins_n <= 1'b0;
    end else if (kcnt_q == 2'd3) begin
      sync_request_pins_n <= 1'b1;
    end else if (lane_is_k_q && lane_octet_q == `SLTC_K_K) begin
      kcnt_q <= kcnt_q + 2'd1;
    end
  end
endmodule

/* File: bench/tb.sv */
// Purpose: self-checking bench of the link transmit control block
// Assumes: receiver model drives the sync pin
// Notes: default frames per multiframe is five, two octets per frame
`timescale 1ns/1ps
module tb;
  reg clk, srst, reg_we, reg_re, sample_valid, allow;
  reg [7:0] reg_addr, reg_wdata;
  reg [13:0] sample_data;
  wire [7:0] reg_rdata_q, lane_octet_q;
  wire [2:0] link_state_q;
  wire [1:0] pk, asm;
  wire sync_n, sample_ready, lane_is_k_q, lane_valid_q, flip;
  wire am, ah, mc;
  integer errors, num_checks, n, i;
  reg [7:0] hi, lo, klo;
  sltc_top dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata_q(reg_rdata_q),
    .sync_request_pins_n(sync_n), .sample_data(sample_data), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .lane_octet_q(lane_octet_q), .lane_is_k_q(lane_is_k_q),
    .lane_valid_q(lane_valid_q), .lane_disparity_flip_q(flip), .packed_output_select_q(pk),
    .frame_assembly_select_low_q(asm), .frame_assembly_select_mid_q(am),
    .frame_assembly_select_high_q(ah), .multiframe_clock_mask_clear_q(mc),
    .link_state_q(link_state_q));
  sltc_rx_model u_rx (.clk(clk), .srst(srst), .allow(allow), .lane_octet_q(lane_octet_q),
    .lane_is_k_q(lane_is_k_q), .sync_request_pins_n(sync_n));
  // ****************************************
  // tasks
  // ****************************************
  task chk(input [7:0] got, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge clk);
      reg_we <= 1'b0;
    end
  endtask
  task rc(input [7:0] a, input [7:0] exp);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge clk);
      reg_re <= 1'b0;
      @(negedge clk);
      chk(reg_rdata_q, exp);
    end
  endtask
  task push(input [13:0] d);
    begin
      @(posedge clk);
      sample_data <= d;
      sample_valid <= 1'b1;
      @(negedge clk);
      while (sample_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
      sample_valid <= 1'b0;
    end
  endtask
  task to_data;
    begin
      n = 0;
      for (i = 0; i < 400 && link_state_q !== 3'b100; i = i + 1) begin
        @(negedge clk);
        if (link_state_q === 3'b010) n = n + 1;
      end
    end
  endtask
  task wait_st(input [2:0] s);
    begin
      for (i = 0; i < 300 && link_state_q !== s; i = i + 1) @(negedge clk);
      chk({5'h0, link_state_q}, {5'h0, s});
    end
  endtask
  task get2;
    begin
      @(negedge clk);
      for (i = 0; i < 200 && !(lane_valid_q === 1'b1 && lane_is_k_q === 1'b0); i = i + 1)
        @(negedge clk);
      hi = lane_octet_q;
      @(negedge clk);
      lo = lane_octet_q;
      klo = {7'h0, lane_is_k_q};
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #2000000;
    errors = errors + 1;
    $display("[ERR] %0t watchdog expired", $time);
    conclude;
  end
  initial begin
    errors = 0;
    num_checks = 0;
    {srst, reg_we, reg_re, sample_valid, allow} = 5'h10;
    {reg_addr, reg_wdata, sample_data} = 30'h0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rc(8'h01, 8'h00);
    rc(8'h02, 8'h00);
    rc(8'h03, 8'h04);
    chk({5'h0, am, ah, mc}, 8'h04);
    rc(8'h07, 8'h00);
    rc(8'h05, 8'h00);
    wr(8'h01, 8'hff);
    rc(8'h01, 8'h97);
    wr(8'h02, 8'hff);
    rc(8'h02, 8'hcf);
    chk({4'h0, pk, asm}, 8'h0f);
    wr(8'h07, 8'hff);
    rc(8'h07, 8'h1f);
    wr(8'h03, 8'hff);
    rc(8'h03, 8'hff);
    chk({5'h0, am, ah, mc}, 8'h07);
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h00);
    wr(8'h03, 8'h04);
    wr(8'h07, 8'h00);
    repeat (4) push(14'h3fff);
    @(negedge clk);
    chk({7'h0, sample_ready}, 8'h00);
    @(posedge clk);
    allow <= 1'b1;
    to_data;
    chk(n[7:0], 8'd40);
    get2;
    chk(hi, 8'hff);
    chk(lo, 8'hfc);
    wr(8'h02, 8'hc0);
    wait_st(3'b001);
    wr(8'h07, 8'h02);
    wr(8'h01, 8'h80);
    wr(8'h02, 8'h40);
    to_data;
    chk(n[7:0], 8'd24);
    allow <= 1'b0;
    repeat (20) @(negedge clk);
    chk({5'h0, link_state_q}, 8'h04);
    wr(8'h02, 8'h00);
    wait_st(3'b001);
    wr(8'h01, 8'h01);
    allow <= 1'b1;
    to_data;
    chk(n[7:0], 8'd0);
    wr(8'h02, 8'h0c);
    push(14'h3fff);
    get2;
    chk(hi, 8'hff);
    chk(lo, 8'hf0);
    wr(8'h01, 8'h03);
    push(14'h3fff);
    get2;
    chk(lo, `SLTC_K_F);
    chk(klo, 8'h01);
    wr(8'h01, 8'h15);
    @(negedge clk);
    for (i = 0; i < 40 && !(lane_valid_q === 1'b1 && lane_is_k_q === 1'b1); i = i + 1)
      @(negedge clk);
    chk(lane_octet_q, `SLTC_K_A);
    repeat (3) @(negedge clk);
    chk(lane_octet_q, 8'h08);
    wr(8'h01, 8'h01);
    wr(8'h03, 8'h05);
    @(negedge clk);
    for (i = 0; i < 40 && (lane_valid_q !== 1'b1 || lane_octet_q === 8'h00); i = i + 1)
      @(negedge clk);
    hi = lane_octet_q;
    repeat (2) @(negedge clk);
    chk(lane_octet_q, hi + 8'h10);
    wr(8'h03, 8'h24);
    repeat (8) @(negedge clk);
    chk(lane_octet_q, `SLTC_D_215);
    wr(8'h03, 8'h44);
    repeat (8) @(negedge clk);
    chk(lane_octet_q, `SLTC_K_K);
    chk({7'h0, lane_is_k_q}, 8'h01);
    wr(8'h03, 8'h94);
    repeat (4) @(negedge clk);
    chk({7'h0, flip}, 8'h01);
    wr(8'h03, 8'h64);
    repeat (30) @(negedge clk);
    n = 0;
    repeat (100) begin
      @(negedge clk);
      if (link_state_q === 3'b010) n = n + 1;
    end
    chk(n[7:0], 8'd100);
    conclude;
  end
endmodule
